/* File: core/pressure_queue_pkg.sv */
// Purpose: Shared constants for the pressure sample queue
// Assumes: Byte-wide register port driven by a serial bus engine
// Notes:   Offsets are register byte addresses
package pressure_queue_pkg;
  localparam int        SAMPLE_W        = 24;
  localparam int        DEPTH           = 32;
  localparam int        LVL_W           = 5;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h28;
  localparam logic [7:0] ADDR_RESULT_MID  = 8'h29;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h2A;
  localparam logic [7:0] ADDR_QUEUE_CTRL  = 8'h2E;
  localparam logic [7:0] ADDR_QUEUE_STAT  = 8'h2F;
  localparam logic [7:0] ADDR_TRIM_HIGH   = 8'h3A;
  localparam logic [7:0] QUEUE_CTRL_RESET = 8'h00;
  localparam logic [7:0] TRIM_HIGH_RESET  = 8'h00;
  localparam int        MODE_LSB        = 5;
  localparam int        STAT_WTM_BIT    = 7;
  localparam int        STAT_FULL_BIT   = 6;
  localparam int        STAT_EMPTY_BIT  = 5;
  localparam logic [2:0] MODE_BYPASS     = 3'h0;
  localparam logic [2:0] MODE_FILL       = 3'h1;
  localparam logic [2:0] MODE_STREAM     = 3'h2;
  localparam logic [2:0] MODE_STR2FILL   = 3'h3;
  localparam logic [2:0] MODE_BYP2STR    = 3'h4;
  localparam logic [2:0] MODE_MEAN       = 3'h6;
  localparam logic [2:0] MODE_BYP2FILL   = 3'h7;
  typedef enum logic [1:0] {Q_OFF, Q_FILL, Q_STREAM} qop_t;
endpackage : pressure_queue_pkg

/* File: core/sample_ram.sv */
// Purpose: Sample store with registered read data
// Assumes: One write and one read port, same clock
// Notes:   Contents are not reset
`timescale 1ns/1ps
module sample_ram #(
  parameter int W = 24,
  parameter int D = 32,
  parameter int A = 5
) (
  input  wire logic         ref_clk,
  input  wire logic         wr_en,
  input  wire logic [A-1:0] wr_addr,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [A-1:0] rd_addr,
  output logic      [W-1:0] rd_data_ff
);
  logic [W-1:0] mem [D];

  initial begin
    if (D > (1 << A)) $error("sample_ram depth exceeds address range");
  end

  always_ff @(posedge ref_clk) begin
    if (wr_en) mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge ref_clk) begin
    rd_data_ff <= mem[rd_addr];
  end
endmodule : sample_ram

/* File: core/pressure_sample_fifo.sv */
// Purpose: Queue of pressure samples behind the pressure result registers
// Assumes: Byte register port from the serial engine, one pulse per access
// Notes:   Address auto-increment is done here; the 0x2A wrap applies only while the queue is active
`timescale 1ns/1ps
// Notes on behaviour
// - Queue holds thirty-two samples of twenty-four bits from measurements.
// - Three-bit mode field in queue control at 0x2E selects behaviour.
// - Mode 000 keeps queue empty; result registers show latest measurement.
// - Mode 001 pushes each new measurement into the queue until it is full.
// - Watermark interrupt rises at level reaching watermark when enabled.
// - Fill-and-stop mode drops new samples while queue is full.
// - Mode 100 bypasses until trigger, then streams.
// - Mode 110 streams and shows a running average always.
// - Average over 2,4,8,16,32 for codes 1,3,7,15,31; others reserved.
// - Mode 111 bypasses until trigger, then fill-and-stop.
// - Queue modes other than 110 return queue contents on result reads.
// - Each queue read loads the oldest entry; single and burst reads work.
// - Active queue wraps read address from 0x2A back to 0x28.
// - Mode 010 streams, dropping oldest when full.
// - Mode 011 streams until trigger deasserts, then fill-and-stop.
// - Status shows watermark, full, empty flags and five-bit level.
// - Averaging mode hides entries; reads give only the average.
module pressure_sample_fifo
  import pressure_queue_pkg::*;
#(
  parameter int W     = SAMPLE_W,
  parameter int DEP   = DEPTH
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] meas_data,
  input  wire logic         meas_valid,
  input  wire logic         trigger_in,
  input  wire logic         watermark_irq_enable,
  input  wire logic         reg_rd,
  input  wire logic         reg_wr,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  output logic      [7:0]   reg_rdata_ff,
  output logic      [7:0]   next_addr_ff,
  output logic              watermark_irq
);
  localparam int AW = $clog2(DEP);
  localparam int CW = AW + 1;

  initial begin
    if (W != SAMPLE_W || DEP != DEPTH) $error("pressure_sample_fifo: unsupported size");
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0]    queue_control_ff;
  logic [7:0]    pressure_offset_trim_high_ff;
  logic [2:0]    mode;
  logic [LVL_W-1:0] watermark_level;
  logic [1:0]    trig_sync_ff;
  logic          trig_s;
  logic          trig_seen_ff;
  qop_t          op;
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic [W-1:0]  live_ff;
  logic [W+AW-1:0] sum_ff;
  logic [W-1:0]  ram_q;
  logic [W-1:0]  result_ff;
  logic          full;
  logic          empty;
  logic          push;
  logic          drop_old;
  logic          pop;
  logic [W-1:0]  old_sample;
  logic [CW-1:0] avg_n;
  logic [2:0]    avg_sh;
  logic [W-1:0]  avg;
  logic [7:0]    status;
  logic          wm_flag;
  logic          ram_valid_ff;
  logic          mean_load;

  assign mode            = queue_control_ff[MODE_LSB +: 3];
  assign watermark_level = queue_control_ff[LVL_W-1:0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      queue_control_ff             <= QUEUE_CTRL_RESET;
      pressure_offset_trim_high_ff <= TRIM_HIGH_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_QUEUE_CTRL) queue_control_ff <= reg_wdata;
      if (reg_addr == ADDR_TRIM_HIGH) pressure_offset_trim_high_ff <= reg_wdata;
    end
  end

  // --------------------------------------------------------------------
  // Trigger and mode resolution
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) trig_sync_ff <= 2'h0;
    else        trig_sync_ff <= {trig_sync_ff[0], trigger_in};
  end
  assign trig_s = trig_sync_ff[1];

  // Trigger event latches until the mode register is rewritten
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) trig_seen_ff <= 1'b0;
    else if (reg_wr && reg_addr == ADDR_QUEUE_CTRL) trig_seen_ff <= 1'b0;
    else if (mode == MODE_STR2FILL ? !trig_s : trig_s) trig_seen_ff <= 1'b1;
  end

  always_comb begin
    case (mode)
      MODE_BYPASS:   op = Q_OFF;
      MODE_FILL:     op = Q_FILL;
      MODE_STREAM:   op = Q_STREAM;
      MODE_STR2FILL: op = trig_seen_ff ? Q_FILL : Q_STREAM;
      MODE_BYP2STR:  op = trig_seen_ff ? Q_STREAM : Q_OFF;
      MODE_MEAN:     op = Q_STREAM;
      MODE_BYP2FILL: op = trig_seen_ff ? Q_FILL : Q_OFF;
      default:       op = Q_OFF;
    endcase
  end

  // --------------------------------------------------------------------
  // Queue storage and pointers
  // --------------------------------------------------------------------
  assign full     = (count_ff == CW'(DEP));
  assign empty    = (count_ff == '0);
  // Fill mode drops new data when full; stream overwrites the oldest
  assign push     = meas_valid && (op == Q_STREAM || (op == Q_FILL && !full));
  // Averaging keeps at most the window in the queue; the oldest leaves each push once count reaches avg_n
  assign drop_old = push && (full || (mode == MODE_MEAN && count_ff >= avg_n));
  // Selecting averaging restarts the queue so it only holds window samples
  assign mean_load = reg_wr && reg_addr == ADDR_QUEUE_CTRL
                     && reg_wdata[MODE_LSB +: 3] == MODE_MEAN;
  // Popping reads happen on the high byte; averaging hides entries
  assign pop      = reg_rd && reg_addr == ADDR_RESULT_HIGH && op != Q_OFF
                    && mode != MODE_MEAN && !empty;

  sample_ram #(.W(W), .D(DEP), .A(AW)) u_ram (
    .ref_clk    (ref_clk),
    .wr_en      (push),
    .wr_addr    (wr_ptr_ff),
    .wr_data    (meas_data),
    .rd_addr    (rd_ptr_ff),
    .rd_data_ff (ram_q)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else if (op == Q_OFF || mean_load) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
      if (pop || drop_old) rd_ptr_ff <= rd_ptr_ff + AW'(1);
      if (push && !drop_old && !pop) count_ff <= count_ff + CW'(1);
      else if (pop && !(push && !drop_old)) count_ff <= count_ff - CW'(1);
    end
  end

  // Memory read data valid one cycle after the pointer settles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ram_valid_ff <= 1'b0;
    else        ram_valid_ff <= !(push || pop || drop_old);
  end

  // --------------------------------------------------------------------
  // Running average
  // --------------------------------------------------------------------
  function automatic logic [2:0] avg_shift(input logic [LVL_W-1:0] code);
    case (code)
      5'h01:   avg_shift = 3'h1;
      5'h03:   avg_shift = 3'h2;
      5'h07:   avg_shift = 3'h3;
      5'h0F:   avg_shift = 3'h4;
      5'h1F:   avg_shift = 3'h5;
      default: avg_shift = 3'h1;
    endcase
  endfunction : avg_shift

  assign avg_sh = avg_shift(watermark_level);
  assign avg_n  = CW'(1) << avg_sh;

  // Window sum over the newest avg_n samples; oldest leaves when count hits avg_n
  assign old_sample = ram_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) sum_ff <= '0;
    else if (mode != MODE_MEAN || (reg_wr && reg_addr == ADDR_QUEUE_CTRL)) sum_ff <= '0;
    else if (meas_valid) begin
      if (count_ff >= avg_n)
        sum_ff <= sum_ff + (W+AW)'(meas_data) - (W+AW)'(old_sample);
      else
        sum_ff <= sum_ff + (W+AW)'(meas_data);
    end
  end
  assign avg = W'(sum_ff >> avg_sh);

  // --------------------------------------------------------------------
  // Result and status
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) live_ff <= '0;
    else if (meas_valid) live_ff <= meas_data;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) result_ff <= '0;
    else if (op == Q_OFF) result_ff <= live_ff;
    else if (mode == MODE_MEAN) result_ff <= avg;
    else if (ram_valid_ff && !empty && !(reg_rd && reg_addr == ADDR_RESULT_LOW))
      result_ff <= ram_q;
  end

  assign wm_flag = count_ff >= CW'(watermark_level);
  assign status  = {wm_flag, full, empty, (LVL_W)'(count_ff)};
  assign watermark_irq = watermark_irq_enable && wm_flag && op != Q_OFF
                         && watermark_level != '0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata_ff <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        ADDR_RESULT_LOW:  reg_rdata_ff <= result_ff[7:0];
        ADDR_RESULT_MID:  reg_rdata_ff <= result_ff[15:8];
        ADDR_RESULT_HIGH: reg_rdata_ff <= result_ff[23:16];
        ADDR_QUEUE_CTRL:  reg_rdata_ff <= queue_control_ff;
        ADDR_QUEUE_STAT:  reg_rdata_ff <= status;
        ADDR_TRIM_HIGH:   reg_rdata_ff <= pressure_offset_trim_high_ff;
        default:          reg_rdata_ff <= 8'h00;
      endcase
    end
  end

  // Auto-increment address for the serial engine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) next_addr_ff <= 8'h00;
    else if (reg_rd || reg_wr) begin
      if (reg_addr == ADDR_RESULT_HIGH && op != Q_OFF)
        next_addr_ff <= ADDR_RESULT_LOW;
      else
        next_addr_ff <= reg_addr + 8'h01;
    end
  end

endmodule : pressure_sample_fifo

/* File: test/pressure_sample_fifo_asserts.sv */
// Purpose: Port checks for the pressure queue
// Assumes: One clock, async low reset
// Notes:   Bound to the queue top
`timescale 1ns/1ps
module queue_checker (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       watermark_irq_enable,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic [7:0] next_addr_ff,
  input wire logic       watermark_irq
);
  // --------------
  // Port relations
  // --------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence rd_at(a); reg_rd && reg_addr == a; endsequence
  sequence wr_ctrl; reg_wr && reg_addr == 8'h2E; endsequence
  ctrl_readback_a: assert property (wr_ctrl ##2 rd_at(8'h2E) |=>
    reg_rdata_ff == $past(reg_wdata, 3)) else $error("control readback wrong");
  data_holds_a: assert property (!reg_rd && !reg_wr |=> $stable(reg_rdata_ff))
    else $error("read data moved without access");
  addr_holds_a: assert property (!reg_rd && !reg_wr |=> $stable(next_addr_ff))
    else $error("next address moved without access");
  addr_step_a: assert property (reg_rd && reg_addr != 8'h2A |=>
    next_addr_ff == $past(reg_addr) + 8'h01) else $error("next address not incremented");
  addr_wrap_a: assert property (rd_at(8'h2A) |=> next_addr_ff inside {8'h28, 8'h2B})
    else $error("high byte read gave bad next address");
  irq_gate_a: assert property (!watermark_irq_enable |-> !watermark_irq)
    else $error("watermark interrupt while disabled");
  irq_flag_a: assert property (reg_rd && reg_addr == 8'h2F && watermark_irq |=>
    reg_rdata_ff[7]) else $error("interrupt without watermark flag");
  flags_excl_a: assert property (rd_at(8'h2F) |=> !(reg_rdata_ff[6] && reg_rdata_ff[5]))
    else $error("full and empty together");
  empty_level_a: assert property (rd_at(8'h2F) ##1 reg_rdata_ff[5] |->
    reg_rdata_ff[4:0] == 5'h00) else $error("empty with nonzero level");
endmodule : queue_checker
bind pressure_sample_fifo queue_checker chk (.*);

/* File: test/host_model.sv */
// Purpose: Host side of the register port
// Assumes: Byte accesses, one strobe per access
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/1ps
module host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata_ff,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_rd    = 1'h0;
    reg_wr    = 1'h0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Strobe for one taking edge, answer taken one edge later
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    reg_rd    <= !w;
    reg_wr    <= w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_rd    <= 1'h0;
    reg_wr    <= 1'h0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    @(posedge ref_clk);
    q = reg_rdata_ff;
  endtask : acc
endmodule : host_model

/* File: test/pressure_sample_fifo_bench.sv */
// Purpose: Self-checking bench for the pressure queue
// Assumes: Host model drives the register port
// Notes:   Queue contents modelled in an int queue
`timescale 1ns/1ps
module pressure_sample_fifo_bench;
  logic        ref_clk, rst_n, meas_valid, trigger_in, watermark_irq_enable, watermark_irq;
  logic        reg_rd, reg_wr;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_ff, next_addr_ff, b;
  logic [23:0] meas_data, w;
  logic [31:0] seed = 32'h9EE65906;
  logic [4:0]  codes[6] = '{5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F, 5'h00};
  logic [2:0]  tmodes[4] = '{3'h4, 3'h7, 3'h5, 3'h3};
  int          err_count, comparisons, qmode, wl, last, q[$];
  pressure_sample_fifo dut (.*);
  host_model host (.*);
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [23:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[23:0];
  endfunction : rnd
  function automatic int avg();
    int n, s;
    n = wl inside {1, 3, 7, 15, 31} ? wl + 1 : 2;
    s = 0;
    for (int i = q.size() - n; i < q.size(); i++) s += q[i];
    return s / n;
  endfunction : avg
  task automatic check(input logic [23:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic push(input logic [23:0] d);
    meas_data  <= d;
    meas_valid <= 1'h1;
    @(posedge ref_clk);
    meas_valid <= 1'h0;
    @(posedge ref_clk);
    last = d;
    if (qmode == 1 && q.size() < 32 || qmode > 1) q.push_back(d);
    if (q.size() > 32) void'(q.pop_front());
  endtask : push
  task automatic pop();
    logic [7:0] a;
    a = 8'h28;
    @(posedge ref_clk);
    repeat (3) begin
      host.acc(1'h0, a, 8'h00, b);
      w = {b, w[23:8]};
      a = next_addr_ff;
    end
    check(a, qmode != 0 ? 8'h28 : 8'h2B);
    check(w, qmode == 3 ? 24'(avg()) : qmode != 0 ? 24'(q.pop_front()) : 24'(last));
    repeat (2) @(posedge ref_clk);
  endtask : pop
  task automatic stat();
    logic [7:0] e, m;
    int n;
    n = q.size();
    check(watermark_irq, watermark_irq_enable && qmode != 0 && wl != 0 && n >= wl);
    e = {n >= wl, n == 32, n == 0, 5'(n)};
    m = {wl != 0, 2'h3, {5{n < 32}}};
    host.acc(1'h0, 8'h2F, 8'h00, b);
    check(b & m, e & m);
  endtask : stat
  task automatic setmode(input logic [2:0] md, input logic [4:0] wm);
    host.acc(1'h1, 8'h2E, {md, wm}, b);
    host.acc(1'h0, 8'h2E, 8'h00, b);
    check(b, {md, wm});
    wl = wm;
    qmode = md == 3'h1 || md == 3'h3 ? 1 : md == 3'h2 ? 2 : md == 3'h6 ? 3 : 0;
    if (qmode == 0) q.delete();
  endtask : setmode
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  initial begin
    rst_n = 1'h0;
    meas_valid = 1'h0;
    meas_data = 24'h000000;
    trigger_in = 1'h0;
    watermark_irq_enable = 1'h0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    setmode(3'h0, 5'h00);
    host.acc(1'h0, 8'h50, 8'h00, b);
    check(b, 8'h00);
    host.acc(1'h1, 8'h3A, 8'hA5, b);
    host.acc(1'h0, 8'h3A, 8'h00, b);
    check(b, 8'hA5);
    push(rnd());
    pop();
    watermark_irq_enable <= 1'h1;
    setmode(3'h1, 5'h03);
    repeat (33) begin
      push(rnd());
      stat();
    end
    repeat (32) begin
      pop();
      stat();
    end
    setmode(3'h2, 5'h03);
    repeat (34) push(rnd());
    repeat (3) pop();
    host.acc(1'h1, 8'h10, 8'h05, b);
    host.acc(1'h1, 8'h21, 8'h40, b);
    foreach (codes[i]) begin
      setmode(3'h6, codes[i]);
      repeat (32) push(rnd());
      repeat (4) @(posedge ref_clk);
      pop();
    end
    foreach (tmodes[i]) begin
      setmode(tmodes[i], 5'h01);
      push(rnd());
      stat();
      trigger_in <= 1'h1;
      repeat (4) @(posedge ref_clk);
      qmode = tmodes[i] == 3'h4 ? 2 : tmodes[i] == 3'h7 || tmodes[i] == 3'h3 ? 1 : 0;
      push(rnd());
      stat();
      trigger_in <= 1'h0;
      repeat (4) @(posedge ref_clk);
    end
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end
endmodule : pressure_sample_fifo_bench
